// file: core/fih_defines.vh
// Purpose: constants for the flash identity, input register and operation timer
// Assumes: 25 MHz core clock
// Notes: times kept in their printed unit; cycle counts derived below
`ifndef FIH_DEFINES_VH
`define FIH_DEFINES_VH

`define FIH_CLK_KHZ 25000
// register addresses on the host memory map
`define FIH_ADDR_GPI 28'hfbc0100
`define FIH_ADDR_MAKER 28'hfbc0000
// general input register layout
`define FIH_GPI_MSB 4
`define FIH_GPI_W 5
// operation kinds
`define FIH_OP_PROG2 3'h0
`define FIH_OP_PROG4 3'h1
`define FIH_OP_SECT_ERASE 3'h2
`define FIH_OP_BLK_ERASE 3'h3
// times in microseconds
`define FIH_PROG_TYP_US 10
`define FIH_PROG_MAX_US 200
`define FIH_SUSP_PROG_MAX_US 5
`define FIH_SUSP_ERASE_MAX_US 30
// times in milliseconds
`define FIH_BLK_PROG_TYP_MS 100
`define FIH_BLK_PROG_MAX_MS 5000
`define FIH_SECT_ERASE_HV_MAX_MS 4000
`define FIH_SECT_ERASE_LV_MAX_MS 5000
`define FIH_BLK_ERASE_HV_MAX_MS 8000
`define FIH_BLK_ERASE_LV_MAX_MS 10000
`define FIH_SECT_ERASE_HV_TYP_MS 400
`define FIH_SECT_ERASE_LV_TYP_MS 500
`define FIH_BLK_ERASE_HV_TYP_MS 750
`define FIH_BLK_ERASE_LV_TYP_MS 1000
// cycle counts: maxima and typicals are both exact at 25 MHz
`define FIH_US_CYC(t) (((t) * `FIH_CLK_KHZ) / 1000)
`define FIH_MS_CYC(t) ((t) * `FIH_CLK_KHZ)
`define FIH_PROG_TYP_CYC `FIH_US_CYC(`FIH_PROG_TYP_US)
`define FIH_SUSP_PROG_CYC `FIH_US_CYC(`FIH_SUSP_PROG_MAX_US)
`define FIH_SUSP_ERASE_CYC `FIH_US_CYC(`FIH_SUSP_ERASE_MAX_US)

`endif

// file: core/fih_regs.v
// Purpose: general input and maker identity registers plus program/erase timer
// Assumes: single 25 MHz clock, host access strobes synchronous to it
// Notes: operation durations are parameters so simulation can shorten them
`timescale 1ns/10ps
`include "fih_defines.vh"

module fih_regs #(
	parameter [7:0] MAKER_ID = 8'h5a, // arbitrary value
	parameter [31:0] PROG_CYC = `FIH_PROG_TYP_CYC,
	parameter [31:0] SECT_ERASE_HV_CYC = `FIH_MS_CYC(`FIH_SECT_ERASE_HV_TYP_MS),
	parameter [31:0] SECT_ERASE_LV_CYC = `FIH_MS_CYC(`FIH_SECT_ERASE_LV_TYP_MS),
	parameter [31:0] BLK_ERASE_HV_CYC = `FIH_MS_CYC(`FIH_BLK_ERASE_HV_TYP_MS),
	parameter [31:0] BLK_ERASE_LV_CYC = `FIH_MS_CYC(`FIH_BLK_ERASE_LV_TYP_MS),
	parameter [31:0] SUSP_PROG_CYC = `FIH_SUSP_PROG_CYC,
	parameter [31:0] SUSP_ERASE_CYC = `FIH_SUSP_ERASE_CYC
) (
	input wire i_mclk,
	input wire i_rst_n,
	input wire i_rd,
	input wire i_wr,
	input wire [27:0] i_addr,
	input wire [`FIH_GPI_MSB:0] i_general_input_pins,
	input wire i_op_start,
	input wire [2:0] i_op_kind,
	input wire i_vpp_high,
	input wire i_hub_mode,
	input wire i_suspend,
	input wire i_resume,
	output reg [7:0] o_rdata,
	output reg o_rvalid,
	output wire o_ready,
	output wire o_suspended,
	output reg o_error
);

localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_RUN = 4'h2;
localparam [3:0] ST_HALTING = 4'h4;
localparam [3:0] ST_PAUSED = 4'h8;

reg [3:0] state;
reg [3:0] next_state;
wire [31:0] remain;
wire [31:0] halt_cnt;
wire remain_last;
wire halt_last;
wire remain_load;
wire halt_load;
wire sel_gpi;
wire sel_maker;
reg [7:0] next_rdata;
reg [31:0] susp_len;
reg ready_now;
reg paused_now;
reg is_erase;
reg [31:0] op_len;
reg op_ok;

////////////////////////////////////////////////////////////////////////////////
// address decode; only the two register offsets select data, others answer zero
assign sel_gpi = (i_addr == `FIH_ADDR_GPI);
assign sel_maker = (i_addr == `FIH_ADDR_MAKER);

// read data select; writes have no target so i_wr changes nothing
always @* begin
	next_rdata = 8'h00; // unmapped reads as zero
	if (sel_gpi) begin
		// pins taken in the read cycle itself; host keeps them steady
		next_rdata = {3'h0, i_general_input_pins}; // reserved bits read zero
	end else if (sel_maker) begin
		next_rdata = MAKER_ID;
	end
end

// read data register; holds the last answer until the next read,
// so a host that samples late still sees the value it asked for
always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_rdata <= 8'h00;
		o_rvalid <= 1'b0;
	end else begin
		o_rvalid <= i_rd; // one cycle answer
		if (i_rd) begin
			o_rdata <= next_rdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// start legality; programs need the high supply, erase may run at either
always @* begin
	op_ok = 1'b1;
	case (i_op_kind)
	`FIH_OP_PROG2: begin
		op_ok = i_vpp_high & i_hub_mode; // double bytes only over the hub protocol
	end
	`FIH_OP_PROG4: begin
		op_ok = i_vpp_high;
	end
	`FIH_OP_SECT_ERASE: begin
		op_ok = 1'b1;
	end
	`FIH_OP_BLK_ERASE: begin
		op_ok = 1'b1;
	end
	default: begin
		op_ok = 1'b0; // unused kinds are refused
	end
	endcase
end

// operation length; typical figures keep every kind well under its maximum
always @* begin
	op_len = PROG_CYC;
	case (i_op_kind)
	`FIH_OP_PROG2: begin
		op_len = PROG_CYC;
	end
	`FIH_OP_PROG4: begin
		// repeated quads make up a block program at one typical each
		op_len = PROG_CYC;
	end
	`FIH_OP_SECT_ERASE: begin
		op_len = i_vpp_high ? SECT_ERASE_HV_CYC : SECT_ERASE_LV_CYC;
	end
	`FIH_OP_BLK_ERASE: begin
		op_len = i_vpp_high ? BLK_ERASE_HV_CYC : BLK_ERASE_LV_CYC;
	end
	default: begin
		op_len = PROG_CYC;
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// controller state transitions
always @* begin
	next_state = state;
	case (state)
	ST_IDLE: begin
		// refused starts stay idle and only raise o_error
		if (i_op_start && op_ok) begin
			next_state = ST_RUN;
		end
	end
	ST_RUN: begin
		// a suspend in the final run cycle is ignored; the operation just ends
		if (remain_last) begin
			next_state = ST_IDLE;
		end else if (i_suspend) begin
			next_state = ST_HALTING;
		end
	end
	ST_HALTING: begin
		// remaining work stays frozen until the halt countdown ends
		if (halt_last) begin
			next_state = ST_PAUSED;
		end
	end
	ST_PAUSED: begin
		// paused counts as ready; only a resume leaves
		if (i_resume) begin
			next_state = ST_RUN;
		end
	end
	default: begin
		next_state = ST_IDLE;
	end
	endcase
end

// state register
always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		state <= ST_IDLE;
	end else begin
		state <= next_state;
	end
end

// kind and error latched at each start; o_error only moves on a start
always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		is_erase <= 1'b0;
		o_error <= 1'b0;
	end else if (state == ST_IDLE && i_op_start) begin
		o_error <= ~op_ok; // sticky until next start
		is_erase <= i_op_kind[1];
	end
end

////////////////////////////////////////////////////////////////////////////////
// remaining work; frozen while halting or paused so resume continues it
assign remain_load = (state == ST_IDLE) && i_op_start;

fih_downcnt #(
	.W(32)
) remain_u (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_load(remain_load),
	.i_load_val(op_len),
	.i_dec(state == ST_RUN),
	.o_count(remain),
	.o_last(remain_last)
);

// suspend latency bounded by the kind being suspended
always @* begin
	if (is_erase) begin
		susp_len = SUSP_ERASE_CYC;
	end else begin
		susp_len = SUSP_PROG_CYC;
	end
end

// halt countdown, loaded by a suspend while running
assign halt_load = (state == ST_RUN) && i_suspend;

fih_downcnt #(
	.W(32)
) halt_u (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_load(halt_load),
	.i_load_val(susp_len),
	.i_dec(state == ST_HALTING),
	.o_count(halt_cnt),
	.o_last(halt_last)
);

////////////////////////////////////////////////////////////////////////////////
// status decode from the one-hot state; busy while running or halting
always @* begin
	ready_now = 1'b0;
	paused_now = 1'b0;
	case (state)
	ST_IDLE: begin
		ready_now = 1'b1;
	end
	ST_RUN: begin
		ready_now = 1'b0;
	end
	ST_HALTING: begin
		ready_now = 1'b0; // still busy until paused
	end
	ST_PAUSED: begin
		ready_now = 1'b1;
		paused_now = 1'b1;
	end
	default: begin
		ready_now = 1'b0;
	end
	endcase
end

assign o_ready = ready_now;
assign o_suspended = paused_now;

endmodule

////////////////////////////////////////////////////////////////////////////////
// loadable down counter that stops at zero; o_last flags the final count
// load wins over a decrement so a restart in the same cycle is not lost
module fih_downcnt #(
	parameter W = 32
) (
	input wire i_mclk,
	input wire i_rst_n,
	input wire i_load,
	input wire [W-1:0] i_load_val,
	input wire i_dec,
	output reg [W-1:0] o_count,
	output wire o_last
);

// count register
always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_count <= {W{1'b0}};
	end else if (i_load) begin
		o_count <= i_load_val;
	end else if (i_dec && (o_count != {W{1'b0}})) begin
		o_count <= o_count - {{(W-1){1'b0}}, 1'b1};
	end
end

// one or zero left counts as last, so a zero load cannot hang the caller
assign o_last = (o_count <= {{(W-1){1'b0}}, 1'b1});

endmodule

// file: testbench/fih_regs_props.sv
// Purpose: port assertions of fih_regs
// Assumes: one clock, reset active low
// Notes: suspend is never driven in the last run cycle
`timescale 1ns/10ps
module fih_regs_props #(parameter [7:0] MAKER_ID = 8'h5a, parameter int PROG_CYC = 12,
	parameter int SUSP_ERASE_CYC = 6) (
	input wire i_mclk, input wire i_rst_n, input wire i_rd, input wire [27:0] i_addr,
	input wire [4:0] i_general_input_pins, input wire i_op_start, input wire [2:0] i_op_kind,
	input wire i_vpp_high, input wire i_suspend, input wire [7:0] o_rdata,
	input wire o_rvalid, input wire o_ready, input wire o_suspended);
	localparam int PN = PROG_CYC + 1;
	localparam int SN = SUSP_ERASE_CYC + 1;
	// legal quad program start
	wire go4 = i_op_start && o_ready && !o_suspended && i_op_kind == 3'h1 && i_vpp_high;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////
	// erase bound is the looser one, so it also holds for program suspend
	property p_rv; i_rd |=> o_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_gpi; i_rd && i_addr == 28'hfbc0100 |=> o_rdata == {3'h0, $past(i_general_input_pins)}; endproperty
	a_gpi: assert property (p_gpi) else $error("pin mirror wrong");
	property p_mk; i_rd && i_addr == 28'hfbc0000 |=> o_rdata == MAKER_ID; endproperty
	a_mk: assert property (p_mk) else $error("maker code wrong");
	property p_hold; !i_rd |=> $stable(o_rdata) && !o_rvalid; endproperty
	a_hold: assert property (p_hold) else $error("data moved without read");
	property p_run; go4 |=> !o_ready [*8]; endproperty
	a_run: assert property (p_run) else $error("not busy in program");
	property p_len; go4 |-> ##PN o_ready; endproperty
	a_len: assert property (p_len) else $error("program too long");
	property p_susp; i_suspend && !o_ready |-> ##[1:SN] o_suspended; endproperty
	a_susp: assert property (p_susp) else $error("pause too late");
	property p_pause; o_suspended |-> o_ready; endproperty
	a_pause: assert property (p_pause) else $error("paused but busy");
	// main scenarios
	c_go4: cover property (go4);
	c_pause: cover property ($rose(o_suspended));
	c_gpi: cover property (i_rd && i_addr == 28'hfbc0100);
endmodule
bind fih_regs fih_regs_props #(.MAKER_ID(MAKER_ID), .PROG_CYC(PROG_CYC),
	.SUSP_ERASE_CYC(SUSP_ERASE_CYC)) u_props (.*);

// file: testbench/fih_pin_src.sv
// Purpose: board model driving the general inputs
// Assumes: reads are one-cycle strobes
// Notes: pins move every idle cycle to expose stale sampling
`timescale 1ns/10ps
module fih_pin_src (input wire i_mclk, input wire i_rd, output logic [4:0] o_pins);
	initial o_pins = 5'h00;
	// levels held while a read is on the bus
	always @(posedge i_mclk) begin
		if (!i_rd) o_pins <= #1 5'($urandom);
	end
endmodule

// file: testbench/fih_regs_tb.sv
// Purpose: self-checking bench for fih_regs
// Assumes: op lengths shortened by parameters
// Notes: pin model moves inputs between reads
`timescale 1ns/10ps
module fih_regs_tb;
	localparam int PC = 12;
	localparam int SE = 16;
	localparam int BE = 20;
	localparam int SP = 3;
	localparam int SS = 6;
	localparam logic [7:0] MK = 8'h3c;
	logic i_mclk = 0, i_rst_n = 0, i_rd = 0, i_wr = 0, i_op_start = 0, i_vpp_high = 0;
	logic i_hub_mode = 0, i_suspend = 0, i_resume = 0;
	logic [27:0] i_addr = 28'h0;
	logic [2:0] i_op_kind = 3'h0;
	logic [7:0] e;
	wire [4:0] p;
	wire [7:0] o_rdata;
	wire o_rvalid, o_ready, o_suspended, o_error;
	int fails = 0, comparisons = 0, n;
	// clock
	always #20 i_mclk = ~i_mclk;
	fih_pin_src src_u (.i_mclk, .i_rd, .o_pins(p));
	fih_regs #(.MAKER_ID(MK), .PROG_CYC(PC), .SECT_ERASE_HV_CYC(SE), .SECT_ERASE_LV_CYC(SE + 2),
		.BLK_ERASE_HV_CYC(BE), .BLK_ERASE_LV_CYC(BE + 2), .SUSP_PROG_CYC(SP), .SUSP_ERASE_CYC(SS))
		dut_u (.i_mclk, .i_rst_n, .i_rd, .i_wr, .i_addr, .i_general_input_pins(p), .i_op_start,
		.i_op_kind, .i_vpp_high, .i_hub_mode, .i_suspend, .i_resume, .o_rdata, .o_rvalid,
		.o_ready, .o_suspended, .o_error);
	// cycles from start to ready; erase lengths are 16/20 high supply, +2 low
	function automatic int olen(int k, int c);
		if (k > 3 || (k < 2 && c < 2) || (k == 0 && c == 2)) return 1;
		return k < 2 ? PC + 1 : 9 + 4 * k + (c < 2 ? 2 : 0);
	endfunction
	task chk(logic [31:0] s, logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			fails++;
			$display("MISMATCH %0t got %0h want %0h", $time, s, x);
		end
	endtask
	task print_verdict;
		if (fails == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task tick;
		@(posedge i_mclk);
		#1;
	endtask
	// bounded count of cycles until ready (0) or paused (1)
	task waitfor(input int w);
		n = 0;
		do begin
			tick;
			{i_op_start, i_suspend, i_resume} = 3'h0;
			n++;
		end while ((w ? o_suspended : o_ready) !== 1'b1 && n < 99);
	endtask
	initial begin
		void'($urandom(32'h171c));
		repeat (12) @(posedge i_mclk);
		#1 i_rst_n = 1;
		// reads over both registers and a hole, random writes beside them
		repeat (40) begin
			tick;
			i_addr = 28'hfbc0000 + 28'h80 * 28'($urandom % 3);
			{i_rd, i_wr} = {1'b1, 1'($urandom)};
			tick;
			// pins are frozen by the model across the read edge, so read them now
			e = i_addr[8] ? {3'h0, p} : i_addr[7] ? 8'h00 : MK;
			{i_rd, i_wr} = 2'h0;
			chk(o_rvalid, 1);
			chk(o_rdata, e);
		end
		// kinds 0 to 4 under each supply and hub setting, back to back
		for (int c = 0; c < 20; c++) begin
			{i_op_kind, i_vpp_high, i_hub_mode, i_op_start} = {5'(c), 1'b1};
			waitfor(0);
			chk(n, olen(c / 4, c % 4));
			chk(o_error, olen(c / 4, c % 4) == 1);
		end
		// suspend a program, then an erase, and resume each
		for (int k = 0; k < 3; k += 2) begin
			{i_op_kind, i_vpp_high, i_hub_mode, i_op_start} = {3'(k), 3'h7};
			tick;
			{i_op_start, i_suspend} = 2'h1;
			waitfor(1);
			chk(n, k ? 7 : 4);
			chk(o_ready, 1);
			i_resume = 1;
			waitfor(0);
			chk(o_suspended, 0);
		end
		print_verdict;
	end
endmodule
